// >>> dv/psl_mac_model.sv
// Purpose: MAC side model: strap resistors and transmit nibbles
// Assumes: pins read the strap level whenever the device does not drive
// Notes: nibbles change just after each transmit clock rise
`timescale 1ns/1ns
`default_nettype none
module psl_mac_model (
  input wire logic [11:0] strap_v,
  input wire logic [11:0] dpin_o,
  input wire logic [11:0] dpin_oe,
  input wire logic mii_txc,
  output logic [11:0] dpin_i,
  output logic mii_txen,
  output logic [3:0] mii_txd
);
  // Resistor level unless the device drives the pin
  assign dpin_i = (dpin_oe & dpin_o) | (~dpin_oe & strap_v);
  // New nibble per clock, always qualified by enable
  initial begin
    mii_txen = 1'b0;
    mii_txd = 4'h0;
  end
  always @(posedge mii_txc) begin
    mii_txen <= 1'b1;
    mii_txd <= mii_txd + 4'h1;
  end
endmodule // psl_mac_model
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for strap latch and MII pins
// Assumes: APB answers at once; pins settle within 8 cycles
// Notes: strap rows first, then pin and register cases
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chip_reset_n;
  logic [11:0] paddr, strap_v, dpin_i, dpin_o, dpin_oe;
  logic [31:0] pwdata, prdata, rd;
  logic mii_txc, mii_txen, tx_strobe, link_up, activity, rx_crs, e;
  logic [3:0] mii_txd;
  logic mdc, mdio, md_oe;
  logic [15:0] mv;
  psl_pkg::psl_nib_t rx_nib, tx_nib;
  psl_pkg::psl_strap_t straps;
  int fails = 0, num_checks = 0, i, k;
  // Rows: strap pins, expected straps, expected status [6:4]
  logic [11:0] rp [5] = '{12'hFFF, 12'h000, 12'h008, 12'h2A4, 12'h553};
  logic [13:0] rs [5] = '{14'h1FE7, 14'h2000, 14'h2001, 14'h3242, 14'h2DA4};
  logic [2:0] rt [5] = '{3'h3, 3'h4, 3'h4, 3'h6, 3'h1};
  psl_strap_mii i_psl_strap_mii (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_reset_n(chip_reset_n),
    .dpin_i(dpin_i), .dpin_o(dpin_o), .dpin_oe(dpin_oe), .mii_txc(mii_txc),
    .mii_txen(mii_txen), .mii_txd(mii_txd), .mii_txer(1'b0), .mdc(mdc),
    .mdio_i(mdio & ~md_oe), .mdio_o(), .mdio_oe(md_oe), .line_signal_present(),
    .rx_nib(rx_nib),
    .rx_crs(rx_crs), .rx_col(1'b0), .rx_take(), .tx_nib(tx_nib), .tx_strobe(tx_strobe),
    .link_up(link_up), .activity(activity), .line_energy(1'b1), .phy_event(1'b0),
    .straps(straps), .dev_run());
  psl_mac_model i_psl_mac_model (.strap_v(strap_v), .dpin_o(dpin_o), .dpin_oe(dpin_oe),
    .mii_txc(mii_txc), .dpin_i(dpin_i), .mii_txen(mii_txen), .mii_txd(mii_txd));
  ////////////////////////////////////////////////////////////////////////////
  task conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; bounded wait on pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin fails++; conclude(); end
    rd = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk); // Idle cycle, so a following call never drives psel twice in one step
  endtask
  // Management read; data changes while the clock is low, sampled at each rise
  task md_rd(input logic [9:0] pr, output logic [15:0] v);
    logic [63:0] f;
    f = {32'hFFFF_FFFF, 4'h6, pr, 2'h3, 16'hFFFF};
    for (int b = 63; b >= 0; b--) begin
      #62 mdc = 1'b0;
      mdio = f[b];
      #63 mdc = 1'b1;
      v = {v[14:0], mdio & ~md_oe};
    end
    #62 mdc = 1'b0; // Clock stands low between frames
    mdio = 1'b1;
  endtask
  initial begin pclk = 1'b0; forever #5 pclk = ~pclk; end
  initial begin
    presetn = 0; chip_reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; strap_v = '0; rx_nib = '0; rx_crs = 0; link_up = 1; activity = 0;
    mdc = 0; mdio = 1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Strap rows: hold chip reset, release, compare latched record
    for (k = 0; k < 5; k++) begin
      chip_reset_n <= 1'b0; strap_v <= rp[k];
      repeat (6) @(posedge pclk);
      `CHK("oe_in_reset", 12'h000, dpin_oe)
      chip_reset_n <= 1'b1;
      repeat (8) @(posedge pclk);
      `CHK("straps", rs[k], straps)
      apb(1'b0, psl_pkg::OFF_STATUS, '0);
      `CHK("status", rt[k], rd[6:4])
      $display("row %0d done", k);
    end
    // Lamps, active low, default functions with link up at 100M
    `CHK("lamp0_on", 1'b0, dpin_o[psl_pkg::PIN_LAMP0])
    `CHK("lamp1_on", 1'b0, dpin_o[psl_pkg::PIN_LAMP1])
    activity <= 1'b1; rx_nib <= 6'h0F;
    repeat (40) @(posedge pclk);
    `CHK("lamp0_off", 1'b1, dpin_o[psl_pkg::PIN_LAMP0])
    `CHK("rxd_idle", 4'h0, dpin_o[3:0])
    // Register reset value, write back, unmapped refusal
    apb(1'b0, psl_pkg::OFF_CTRL, '0);
    `CHK("ctrl_rst", 6'h24, rd[5:0])
    apb(1'b1, psl_pkg::OFF_CTRL, 32'h0000001A);
    apb(1'b0, psl_pkg::OFF_CTRL, '0);
    `CHK("ctrl_rw", 6'h1A, rd[5:0])
    `CHK("lamp0_link", 1'b0, dpin_o[psl_pkg::PIN_LAMP0])
    apb(1'b0, 12'h010, '0);
    `CHK("unmapped", 1'b1, e)
    `CHK("unmapped_rd", 32'h00000000, rd)
    $display("registers done");
    // Management reads; last strap row set address 4, 100M, no negotiation, unique 0
    md_rd({5'h04, 5'h04}, mv);
    `CHK("md_adv", 16'h01E1, mv)
    md_rd({5'h04, 5'h00}, mv);
    `CHK("md_ctl", 16'h2000, mv)
    md_rd({5'h00, 5'h00}, mv);
    `CHK("md_bcast_off", 16'hFFFF, mv)
    $display("management done");
    // Transmit nibble accepted while enable high
    i = 0;
    while (tx_strobe !== 1'b1 && i < 200) begin @(posedge pclk); i++; end
    `CHK("tx_strobe", 1'b1, tx_strobe)
    `CHK("tx_valid", 1'b1, tx_nib.valid)
    $display("transmit done");
    conclude();
  end
  initial begin #500000; fails++; conclude(); end
endmodule // tb_top
`default_nettype wire

// >>> logic/psl_pkg.sv
// Purpose: Shared constants and carriers for the strap latch and MII pin block
// Assumes: pclk at 100 MHz; APB with 32-bit data
// Notes:   Pin indexes describe the shared strap/output pins as one vector
`default_nettype none

package psl_pkg;

  // Clock and MII clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MII100_PERIOD_NS = 40;
  localparam int MII10_PERIOD_NS = 400;
  localparam int HALF100_CYC = MII100_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int HALF10_CYC = MII10_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int DIV_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Shared strap/output pins, index into one vector
  localparam int DPIN_W = 12;
  localparam int PIN_RXD0 = 0;
  localparam int PIN_RXD3 = 3;
  localparam int PIN_RXDV = 4;
  localparam int PIN_CRS = 5;
  localparam int PIN_RXC = 6;
  localparam int PIN_RXER = 7;
  localparam int PIN_COL = 8;
  localparam int PIN_LAMP0 = 9;
  localparam int PIN_LAMP1 = 10;
  localparam int PIN_IRQ = 11;

  // Strap record and its value before any capture
  typedef struct packed {
    logic tree_enable_strap;
    logic emission_filter_disable_strap;
    logic broadcast_addr_disable_strap;
    logic speed_strap;
    logic link_negotiation_strap;
    logic duplex_strap;
    logic [2:0] operating_mode_strap;
    logic [4:0] mgmt_station_addr_strap;
  } psl_strap_t;
  localparam psl_strap_t STRAP_RST = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
                                       3'h0, 5'h01};

  // One MII nibble with its qualifiers
  typedef struct packed {
    logic valid;
    logic err;
    logic [3:0] data;
  } psl_nib_t;

  ////////////////////////////////////////////////////////////////////////////
  // APB map
  localparam logic [11:0] OFF_STRAP = 12'h000;
  localparam logic [11:0] OFF_CTRL = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_EVENT = 12'h00C;
  localparam logic [5:0] CTRL_RST = 6'h24;
  localparam int CTRL_IRQ_HIGH = 4;
  localparam int CTRL_IRQ_EN = 5;

  // Lamp functions
  localparam logic [1:0] LAMP_LINK_ACT = 2'h0;
  localparam logic [1:0] LAMP_SPEED = 2'h1;
  localparam logic [1:0] LAMP_LINK = 2'h2;
  localparam logic [1:0] LAMP_ACT = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Management frame
  localparam logic [5:0] MD_PRE_LEN = 6'h20;
  localparam logic [4:0] MD_REG_CTL = 5'h00;
  localparam logic [4:0] MD_REG_ADV = 5'h04;
  localparam int CTL_SPEED_BIT = 13;
  localparam int CTL_ANEG_BIT = 12;
  localparam int CTL_DUPLEX_BIT = 8;
  localparam logic [3:0] ADV_100 = 4'hF;
  localparam logic [3:0] ADV_10 = 4'h3;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;

endpackage : psl_pkg

`default_nettype wire

// >>> logic/psl_strap_mii.sv
// Purpose: Strap latch, MII pin timing, management port, lamps and irq pin
// Assumes: Pins reach pclk through two flip-flops; pclk at 100 MHz
// Notes:   Shared pins are inputs while chip reset is low, outputs after, except the irq pin, driven only while asserted
//
// Functional notes
// (R1) Every strap is sampled when chip reset ends and held as start-up setup.
// (R2) Shared pins float as inputs during reset, become outputs afterwards; the irq pin is driven only while asserted.
// (R3) Address bits 0,1,2 come from receive data lines 3,2,1.
// (R4) Strapped address spans 0..7, bits 4:3 zero, default 00001.
// (R5) Mode bits 2,1,0 come from data valid, carrier sense, receive clock.
// (R6) Duplex from data line 0, negotiation from lamp 0, speed from lamp 1.
// (R7) Broadcast-address-disable comes from the collision pin.
// (R8) Filter disable from receive error, test tree enable from interrupt pin.
// (R9) Receive nibbles follow the receive clock, meaningful only with data valid.
// (R10) Transmit nibbles follow transmit clock, accepted only while enable high.
// (R11) Transmit clock is made here and driven out.
// (R12) Receive clock is made here and driven out.
// (R13) Unconnected transmit error reads as deasserted via the pull-down.
// (R14) Lamp 0 active low, programmable, default link and activity.
// (R15) Lamp 1 active low, programmable, default link speed.
// (R16) Interrupt polarity programmable, default low; pin only pulls or floats.
// (R17) Management clock comes from the host; data moves on its edges.
// (R18) Low chip reset resets the device; its rising edge samples straps.
// (R19) Speed strap high means 100 Mbps; loads control bit 13 and advert.
// (R20) Duplex strap high means half; inverted into control bit 8.
// (R21) Negotiation strap high enables negotiation; loads control bit 12.
// (R22) Broadcast-disable high makes address 0 unique; low lets it broadcast.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

module psl_strap_mii (
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic chip_reset_n,
  input wire logic [psl_pkg::DPIN_W-1:0] dpin_i,
  output logic [psl_pkg::DPIN_W-1:0] dpin_o,
  output logic [psl_pkg::DPIN_W-1:0] dpin_oe,
  output logic mii_txc,
  input wire logic mii_txen,
  input wire logic [3:0] mii_txd,
  input wire logic mii_txer,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  output logic line_signal_present,
  // Core side
  input wire psl_pkg::psl_nib_t rx_nib,
  input wire logic rx_crs,
  input wire logic rx_col,
  output logic rx_take,
  output psl_pkg::psl_nib_t tx_nib,
  output logic tx_strobe,
  input wire logic link_up,
  input wire logic activity,
  input wire logic line_energy,
  input wire logic phy_event,
  output psl_pkg::psl_strap_t straps,
  output logic dev_run
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int SW = psl_pkg::DPIN_W + 9;
  logic [SW-1:0] sync_q;
  logic [psl_pkg::DPIN_W-1:0] pin_s;
  logic rst_s, rst_d, rst_rise, txen_s, txer_s, mdc_s, mdc_d, mdio_s, md_edge;
  logic [3:0] txd_s;

  psl_sync #(.W(SW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({chip_reset_n, mii_txen, mii_txd, mii_txer, mdc, mdio_i, dpin_i}),
    .q(sync_q)
  );
  assign {rst_s, txen_s, txd_s, txer_s, mdc_s, mdio_s, pin_s} = sync_q;

  // Edge finders on the synchronised reset and management clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_d <= 1'b0;
      mdc_d <= 1'b0;
    end else begin
      rst_d <= rst_s;
      mdc_d <= mdc_s;
    end
  end
  assign rst_rise = rst_s & ~rst_d; // [R18]
  assign md_edge = mdc_s & ~mdc_d; // [R17]
  assign dev_run = rst_d; // Held low while chip reset is low [R18]

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture at the end of chip reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      straps <= psl_pkg::STRAP_RST; // [R4]
    end else if (rst_rise) begin // [R1]
      straps.mgmt_station_addr_strap <= {2'h0, pin_s[1], pin_s[2], pin_s[3]}; // [R3] [R4]
      straps.operating_mode_strap <= {pin_s[psl_pkg::PIN_RXDV],
                                      pin_s[psl_pkg::PIN_CRS],
                                      pin_s[psl_pkg::PIN_RXC]}; // [R5]
      straps.duplex_strap <= pin_s[psl_pkg::PIN_RXD0]; // [R6]
      straps.link_negotiation_strap <= pin_s[psl_pkg::PIN_LAMP0]; // [R6]
      straps.speed_strap <= pin_s[psl_pkg::PIN_LAMP1]; // [R6]
      straps.broadcast_addr_disable_strap <= pin_s[psl_pkg::PIN_COL]; // [R7]
      straps.emission_filter_disable_strap <= pin_s[psl_pkg::PIN_RXER]; // [R8]
      straps.tree_enable_strap <= ~pin_s[psl_pkg::PIN_IRQ]; // Pin is active low [R8]
    end
  end

  strap_capture_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    rst_rise |=> straps.mgmt_station_addr_strap[0] == $past(pin_s[psl_pkg::PIN_RXD3])
      && straps.broadcast_addr_disable_strap == $past(pin_s[psl_pkg::PIN_COL]))
    else $error("straps not taken at reset release");
  mode_capture_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    rst_rise |=> straps.operating_mode_strap == $past({pin_s[psl_pkg::PIN_RXDV],
      pin_s[psl_pkg::PIN_CRS], pin_s[psl_pkg::PIN_RXC]}))
    else $error("mode strap order wrong");
  addr_high_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    straps.mgmt_station_addr_strap[4:3] == 2'h0)
    else $error("address high bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Management registers: control bits and advertised speed
  logic ctl_speed, ctl_aneg, ctl_duplex;
  logic [3:0] adv_speed;
  logic md_wr_hit;
  logic [4:0] md_reg;
  logic [15:0] md_sr;

  // Straps load at reset release; management writes after that
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_speed <= 1'b1;
      ctl_aneg <= 1'b1;
      ctl_duplex <= 1'b0;
      adv_speed <= psl_pkg::ADV_100;
    end else if (rst_rise) begin
      ctl_speed <= pin_s[psl_pkg::PIN_LAMP1]; // [R19]
      adv_speed <= pin_s[psl_pkg::PIN_LAMP1] ? psl_pkg::ADV_100 : psl_pkg::ADV_10; // [R19]
      ctl_duplex <= ~pin_s[psl_pkg::PIN_RXD0]; // High strap is half duplex [R20]
      ctl_aneg <= pin_s[psl_pkg::PIN_LAMP0]; // [R21]
    end else if (md_wr_hit && md_reg == psl_pkg::MD_REG_CTL) begin
      ctl_speed <= md_sr[psl_pkg::CTL_SPEED_BIT];
      ctl_aneg <= md_sr[psl_pkg::CTL_ANEG_BIT];
      ctl_duplex <= md_sr[psl_pkg::CTL_DUPLEX_BIT];
    end else if (md_wr_hit && md_reg == psl_pkg::MD_REG_ADV) begin
      adv_speed <= md_sr[8:5];
    end
  end

  ctl_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
    rst_rise |=> ctl_duplex != $past(pin_s[psl_pkg::PIN_RXD0])
      && ctl_speed == $past(pin_s[psl_pkg::PIN_LAMP1])
      && ctl_aneg == $past(pin_s[psl_pkg::PIN_LAMP0]))
    else $error("control bits not loaded from straps");

  // Read word of a management register
  function automatic logic [15:0] md_word(input logic [4:0] r, input logic sp,
                                          input logic an, input logic dx,
                                          input logic [3:0] adv);
    logic [15:0] w;
    w = 16'h0000;
    if (r == psl_pkg::MD_REG_CTL) begin
      w[psl_pkg::CTL_SPEED_BIT] = sp;
      w[psl_pkg::CTL_ANEG_BIT] = an;
      w[psl_pkg::CTL_DUPLEX_BIT] = dx;
    end else if (r == psl_pkg::MD_REG_ADV) begin
      w[8:5] = adv;
      w[4:0] = psl_pkg::ADV_SELECTOR;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Management frame on the host clock edges
  typedef enum logic [2:0] {
    MD_IDLE = 3'b000,
    MD_ST = 3'b001,
    MD_OP = 3'b010,
    MD_PHY = 3'b011,
    MD_REG = 3'b100,
    MD_TA = 3'b101,
    MD_DATA = 3'b110
  } psl_md_state_t;

  psl_md_state_t md_state;
  logic [5:0] md_pre;
  logic [3:0] md_cnt;
  logic [1:0] md_op;
  logic [4:0] md_phy;
  logic md_drive, md_bit, md_hit;

  // Address 0 answers as broadcast unless the strap makes it unique [R22]
  assign md_hit = (md_phy == straps.mgmt_station_addr_strap) ||
                  (md_phy == 5'h00 && !straps.broadcast_addr_disable_strap);
  assign md_wr_hit = md_edge && md_state == MD_DATA && md_cnt == 4'hF
                     && md_op == 2'b01 && md_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md_state <= MD_IDLE;
      md_pre <= 6'h00;
      md_cnt <= 4'h0;
      md_op <= 2'h0;
      md_phy <= 5'h00;
      md_reg <= 5'h00;
      md_sr <= 16'h0000;
      md_drive <= 1'b0;
      md_bit <= 1'b1;
    end else if (!dev_run) begin
      md_state <= MD_IDLE;
      md_pre <= 6'h00;
      md_drive <= 1'b0;
    end else if (md_edge) begin // [R17]
      md_cnt <= md_cnt + 4'h1;
      unique case (md_state)
        MD_IDLE: begin
          md_cnt <= 4'h0;
          if (mdio_s) begin
            md_pre <= (md_pre == psl_pkg::MD_PRE_LEN) ? md_pre : md_pre + 6'h01;
          end else begin
            md_pre <= 6'h00;
            if (md_pre == psl_pkg::MD_PRE_LEN) md_state <= MD_ST;
          end
        end
        MD_ST: begin
          md_cnt <= 4'h0;
          md_state <= mdio_s ? MD_OP : MD_IDLE;
        end
        MD_OP: begin
          md_op <= {md_op[0], mdio_s};
          if (md_cnt == 4'h1) begin
            md_cnt <= 4'h0;
            md_state <= MD_PHY;
          end
        end
        MD_PHY: begin
          md_phy <= {md_phy[3:0], mdio_s};
          if (md_cnt == 4'h4) begin
            md_cnt <= 4'h0;
            md_state <= MD_REG;
          end
        end
        MD_REG: begin
          if (md_cnt == 4'h4) begin
            md_cnt <= 4'h0;
            md_state <= MD_TA;
            md_sr <= md_word({md_reg[3:0], mdio_s}, ctl_speed, ctl_aneg, ctl_duplex,
                             adv_speed);
          end
          md_reg <= {md_reg[3:0], mdio_s};
        end
        MD_TA: begin
          if (md_cnt == 4'h0) begin
            md_drive <= (md_op == 2'b10) && md_hit; // Turnaround zero
            md_bit <= 1'b0;
          end else begin
            md_cnt <= 4'h0;
            md_state <= MD_DATA;
            md_bit <= md_sr[15];
            if (md_op == 2'b10) md_sr <= {md_sr[14:0], 1'b0};
          end
        end
        MD_DATA: begin
          if (md_op == 2'b10) begin
            md_bit <= md_sr[15];
            md_sr <= {md_sr[14:0], 1'b0};
          end else begin
            md_sr <= {md_sr[14:0], mdio_s};
          end
          if (md_cnt == 4'hF) begin
            md_drive <= 1'b0;
            md_bit <= 1'b1;
            md_state <= MD_IDLE;
          end
        end
        default: md_state <= MD_IDLE;
      endcase
    end
  end

  // Open-drain style: only zeros are pulled, ones left to the pull-up
  assign mdio_o = 1'b0;
  assign mdio_oe = md_drive & ~md_bit;

  md_release_a: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
    md_state == MD_TA && md_edge && md_cnt == 4'h0 && md_phy == 5'h00
      && straps.broadcast_addr_disable_strap && straps.mgmt_station_addr_strap != 5'h00
      |=> !md_drive)
    else $error("unique address 0 answered");

  ////////////////////////////////////////////////////////////////////////////
  // MII clock divider, both clocks generated here
  logic [psl_pkg::DIV_W-1:0] div_cnt, div_half;
  logic mii_clk, mii_rise, mii_fall, div_tick;

  assign div_half = ctl_speed ? psl_pkg::DIV_W'(psl_pkg::HALF100_CYC)
                              : psl_pkg::DIV_W'(psl_pkg::HALF10_CYC);
  assign div_tick = dev_run && (div_cnt >= div_half - psl_pkg::DIV_W'(1));
  assign mii_rise = div_tick & ~mii_clk;
  assign mii_fall = div_tick & mii_clk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      mii_clk <= 1'b0;
    end else if (!dev_run) begin
      div_cnt <= '0;
      mii_clk <= 1'b0;
    end else if (div_tick) begin
      div_cnt <= '0;
      mii_clk <= ~mii_clk; // [R11] [R12]
    end else begin
      div_cnt <= div_cnt + psl_pkg::DIV_W'(1);
    end
  end
  assign mii_txc = mii_clk; // [R11]

  txc_period_a: assert property (@(posedge pclk) disable iff (!presetn || !dev_run) // [R11]
    $rose(mii_txc) && ctl_speed && $stable(ctl_speed) |-> mii_txc ##1 mii_txc ##1 !mii_txc)
    else $error("transmit clock half period wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Receive path: pins change on the falling receive clock, stable at rising
  psl_pkg::psl_nib_t rx_q;
  logic crs_q, col_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= '0;
      crs_q <= 1'b0;
      col_q <= 1'b0;
    end else if (mii_fall) begin
      rx_q.valid <= rx_nib.valid;
      rx_q.err <= rx_nib.err;
      rx_q.data <= rx_nib.valid ? rx_nib.data : 4'h0; // Zero outside a frame [R9]
      crs_q <= rx_crs;
      col_q <= rx_col;
    end
  end
  assign rx_take = mii_fall;

  rx_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    dev_run && !dpin_o[psl_pkg::PIN_RXDV] |-> dpin_o[3:0] == 4'h0)
    else $error("receive data moved without data valid");

  // Transmit path: sample at the rising transmit clock, one full period settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_nib <= '0;
      tx_strobe <= 1'b0;
    end else begin
      tx_strobe <= mii_rise & txen_s; // [R10]
      if (mii_rise) begin
        tx_nib.valid <= txen_s; // [R10]
        tx_nib.err <= txen_s & txer_s; // Floating pin reads low [R13]
        tx_nib.data <= txen_s ? txd_s : 4'h0; // [R10]
      end
    end
  end

  tx_accept_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    tx_strobe |-> tx_nib.valid && $past(txen_s))
    else $error("transmit nibble taken without enable");

  ////////////////////////////////////////////////////////////////////////////
  // APB registers: lamp functions, irq polarity, event flag
  logic [5:0] ctrl;
  logic evt_pend, irq_on, sense_q;
  logic wr_acc, rd_setup, hit;

  assign hit = paddr == psl_pkg::OFF_STRAP || paddr == psl_pkg::OFF_CTRL ||
               paddr == psl_pkg::OFF_STATUS || paddr == psl_pkg::OFF_EVENT;
  assign wr_acc = psel & penable & pwrite & hit;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1; // Zero wait states
  assign pslverr = psel & penable & ~hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= psl_pkg::CTRL_RST; // [R14] [R15] [R16]
    end else if (wr_acc && paddr == psl_pkg::OFF_CTRL) begin
      ctrl <= pwdata[5:0];
    end
  end

  // Event flag: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_pend <= 1'b0;
    end else if (phy_event && dev_run) begin
      evt_pend <= 1'b1;
    end else if (wr_acc && paddr == psl_pkg::OFF_EVENT && pwdata[0]) begin
      evt_pend <= 1'b0;
    end
  end

  // Read data captured in the setup phase so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        psl_pkg::OFF_STRAP: prdata <= {18'h0, straps};
        psl_pkg::OFF_CTRL: prdata <= {26'h0, ctrl};
        psl_pkg::OFF_STATUS: prdata <= {25'h0, ctl_duplex, ctl_aneg, ctl_speed,
                                        dev_run, irq_on, link_up, sense_q};
        psl_pkg::OFF_EVENT: prdata <= {31'h0, evt_pend};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamps, signal detect and interrupt pin
  function automatic logic lamp_fn(input logic [1:0] f, input logic lk,
                                   input logic act, input logic sp);
    unique case (f)
      psl_pkg::LAMP_LINK_ACT: return lk & ~act; // Blinks off on traffic
      psl_pkg::LAMP_SPEED: return lk & sp;
      psl_pkg::LAMP_LINK: return lk;
      psl_pkg::LAMP_ACT: return act;
    endcase
  endfunction

  assign irq_on = evt_pend & ctrl[psl_pkg::CTRL_IRQ_EN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_q <= 1'b0;
    end else begin
      sense_q <= line_energy & dev_run;
    end
  end
  assign line_signal_present = sense_q;

  // Output pins; every shared pin floats while chip reset holds [R2]
  always_comb begin
    dpin_o = '0;
    dpin_o[3:0] = rx_q.data; // [R9]
    dpin_o[psl_pkg::PIN_RXDV] = rx_q.valid;
    dpin_o[psl_pkg::PIN_CRS] = crs_q;
    dpin_o[psl_pkg::PIN_RXC] = mii_clk; // [R12]
    dpin_o[psl_pkg::PIN_RXER] = rx_q.err;
    dpin_o[psl_pkg::PIN_COL] = col_q;
    dpin_o[psl_pkg::PIN_LAMP0] = ~lamp_fn(ctrl[1:0], link_up, activity, ctl_speed); // [R14]
    dpin_o[psl_pkg::PIN_LAMP1] = ~lamp_fn(ctrl[3:2], link_up, activity, ctl_speed); // [R15]
    dpin_o[psl_pkg::PIN_IRQ] = ctrl[psl_pkg::CTRL_IRQ_HIGH]; // Active level [R16]
    dpin_oe = {psl_pkg::DPIN_W{dev_run}}; // [R2]
    dpin_oe[psl_pkg::PIN_IRQ] = dev_run & irq_on; // Pull only when asserted [R16]
  end

  pins_float_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    !rst_s ##1 !rst_s |-> dpin_oe == '0)
    else $error("shared pin driven during chip reset");
  irq_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
    dpin_oe[psl_pkg::PIN_IRQ] |-> evt_pend && dpin_o[psl_pkg::PIN_IRQ] == ctrl[4])
    else $error("irq pin driven without pending event");
  lamp_polarity_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    ctrl[1:0] == psl_pkg::LAMP_LINK && link_up |-> !dpin_o[psl_pkg::PIN_LAMP0])
    else $error("lamp not active low");

endmodule // psl_strap_mii

`default_nettype wire

// >>> logic/psl_sync.sv
// Purpose: Two-flip-flop synchroniser for a bank of pin levels
// Assumes: Each bit is an independent level
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ns
`default_nettype none

module psl_sync #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // Two stages per bit; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule // psl_sync

`default_nettype wire
